// ==== hdl/mcr_stall_timer.sv ====
`timescale 1ns/1ps
`include "mcr_map.svh"
module mcr_stall_timer #(
    parameter int LIMIT = `MCR_STALL_CYCLES
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic s3_stall,
    input wire logic s3_advance,
    output logic expired
);
    localparam int W = $clog2(LIMIT + 1);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_expired;

    // stage 4, field queue and instruction queue stalls arrive via s3_stall
    always_comb
    begin
        next_count = count;
        next_expired = 1'b0;
        if (s3_advance || !s3_stall)
            next_count = '0;
        else if (count == W'(LIMIT - 1))
        begin
            next_expired = 1'b1;
            next_count = '0;
        end
        else
            next_count = count + W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= '0;
            expired <= 1'b0;
        end
        else
        begin
            count <= next_count;
            expired <= next_expired;
        end
    end
endmodule

// ==== hdl/mcr_top.sv ====
`timescale 1ns/1ps
`include "mcr_map.svh"
module mcr_top #(
    parameter int STALL_CYCLES = `MCR_STALL_CYCLES
)(
    input wire logic clk,
    input wire logic rst,
    input mcr_pkg::mcr_ucode_err_t ucode_err,
    input mcr_pkg::mcr_sync_err_t sync_err,
    input mcr_pkg::mcr_lost_t lost,
    input wire logic tb_hit,
    input wire logic tb_parity_err,
    input wire logic tb_lock_clr,
    input wire logic s3_stall,
    input wire logic s3_advance,
    input wire logic stall_timeout_clr,
    input wire logic state_changed,
    input wire logic mchk_ack,
    output logic mchk_trap,
    output logic [31:0] frame_word1,
    output logic [7:0] cause_code,
    output logic restart_indicator,
    output logic tb_lock,
    output logic stall_timeout_flag,
    output logic write_lost,
    output logic soft_err_int,
    output logic hard_err_int
);
    // sticky flag slots, set by hardware and cleared by software
    localparam int N_STICKY = 3;
    localparam int LOCK_IDX = 0;
    localparam int TIMEOUT_IDX = 1;
    localparam int WLOST_IDX = 2;

    mcr_pkg::mcr_state_t state;
    mcr_pkg::mcr_state_t next_state;
    logic [7:0] next_cause_code;
    logic next_restart;
    logic next_trap;
    logic [31:0] next_frame_word1;
    logic [N_STICKY-1:0] sticky;
    logic [N_STICKY-1:0] next_sticky;
    logic [N_STICKY-1:0] sticky_set;
    logic [N_STICKY-1:0] sticky_clr;
    logic next_soft;
    logic next_hard;
    logic timer_expired;
    logic tb_err;
    logic string_err;
    logic ucode_any;
    logic async_err;
    logic sync_take;
    logic fetch_restart;
    logic take_trap;

    // a fetch or read error flagged on the data now in flight
    function automatic logic stream_err(
        input mcr_pkg::mcr_sync_err_t e
    );
        return e.fetch_err || e.read_err;
    endfunction

    // the two string state bits only matter while a move is running
    function automatic logic string_bad(
        input mcr_pkg::mcr_ucode_err_t u
    );
        return u.string_active &&
            (u.string_state == `MCR_STR_ILLEGAL);
    endfunction

    // fixed priority: an async error can strike inside any microflow,
    // so it outranks the microcode checks; a sync error comes last
    function automatic logic [7:0] pick_cause(
        input logic async_hit,
        input mcr_pkg::mcr_ucode_err_t u,
        input logic str_hit
    );
        logic [7:0] code;
        code = `MCR_CODE_SYNC;
        if (async_hit)
            code = `MCR_CODE_ASYNC;
        else if (u.unknown_mm_status)
            code = `MCR_CODE_UNKNOWN_MM;
        else if (u.bad_interrupt_id)
            code = `MCR_CODE_BAD_INT_ID;
        else if (u.impossible_dispatch)
            code = `MCR_CODE_IMPOSSIBLE;
        else if (str_hit)
            code = `MCR_CODE_STRING;
        return code;
    endfunction

    // stage 4, field queue and instruction queue stalls arrive as s3_stall
    mcr_stall_timer #(
        .LIMIT(STALL_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .s3_stall(s3_stall),
        .s3_advance(s3_advance),
        .expired(timer_expired)
    );

    // only a hit entry's parity matters; a miss never used the data
    assign tb_err = tb_hit && tb_parity_err;
    assign string_err = string_bad(ucode_err);
    assign ucode_any = ucode_err.unknown_mm_status ||
        ucode_err.bad_interrupt_id || ucode_err.impossible_dispatch ||
        string_err;
    assign async_err = tb_err || timer_expired;
    // a pte error on a write may land mid-instruction; no state is repaired
    assign sync_take = (stream_err(sync_err) && sync_err.consume) ||
        sync_err.pte_write_err;
    // fetch errors are caught before any visible change, so they restart when the cause picked is sync
    assign fetch_restart = sync_err.fetch_err && sync_err.consume;
    assign take_trap = async_err || ucode_any || sync_take;

    // trap group: state, cause, restart bit and the stacked frame word
    always_comb
    begin
        next_state = state;
        next_cause_code = cause_code;
        next_restart = restart_indicator;
        next_trap = 1'b0;
        unique case (state)
            mcr_pkg::MCR_IDLE:
            begin
                if (take_trap)
                begin
                    next_state = mcr_pkg::MCR_TRAP;
                    next_trap = 1'b1;
                    next_cause_code = pick_cause(async_err, ucode_err,
                        string_err);
                    next_restart = !state_changed;
                    if (next_cause_code == `MCR_CODE_SYNC && fetch_restart)
                        next_restart = 1'b1;
                end
            end
            mcr_pkg::MCR_TRAP:
                next_state = mcr_pkg::MCR_WAIT;
            // later errors wait here until the handler acknowledges
            mcr_pkg::MCR_WAIT:
                if (mchk_ack)
                    next_state = mcr_pkg::MCR_IDLE;
            default:
                next_state = mcr_pkg::MCR_IDLE;
        endcase
        next_frame_word1 = 32'h00000000;
        next_frame_word1[`MCR_CODE_MSB:`MCR_CODE_LSB] =
            next_cause_code;
    end

    // the frame word is registered so the stacked data never glitches
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= mcr_pkg::MCR_IDLE;
            cause_code <= `MCR_CODE_NONE;
            restart_indicator <= 1'b0;
            mchk_trap <= 1'b0;
            frame_word1 <= 32'h00000000;
        end
        else
        begin
            state <= next_state;
            cause_code <= next_cause_code;
            restart_indicator <= next_restart;
            mchk_trap <= next_trap;
            frame_word1 <= next_frame_word1;
        end
    end

    // a set that lands in the clearing cycle wins, so no error is lost
    assign sticky_set[LOCK_IDX] = tb_err;
    assign sticky_clr[LOCK_IDX] = tb_lock_clr;
    assign sticky_set[TIMEOUT_IDX] = timer_expired;
    assign sticky_clr[TIMEOUT_IDX] = stall_timeout_clr;
    assign sticky_set[WLOST_IDX] = lost.write_lost_set;
    assign sticky_clr[WLOST_IDX] = lost.write_lost_clr;

    generate
        for (genvar i = 0; i < N_STICKY; i++)
        begin : g_sticky
            assign next_sticky[i] = sticky_set[i] ||
                (sticky[i] && !sticky_clr[i]);
        end
    endgenerate

    // one register for all flags; clears arrive as one-cycle pulses
    always_ff @(posedge clk)
    begin
        if (rst)
            sticky <= '0;
        else
            sticky <= next_sticky;
    end

    assign tb_lock = sticky[LOCK_IDX];
    assign stall_timeout_flag = sticky[TIMEOUT_IDX];
    assign write_lost = sticky[WLOST_IDX];

    // interrupt group: both follow their condition one cycle late
    always_comb
    begin
        // prefetched data dropped before use: no check, soft interrupt
        next_soft = stream_err(sync_err) && sync_err.discard &&
            !sync_err.consume;
        next_hard = next_sticky[WLOST_IDX] ||
            (lost.lost_err && lost.lost_data);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            soft_err_int <= 1'b0;
            hard_err_int <= 1'b0;
        end
        else
        begin
            soft_err_int <= next_soft;
            hard_err_int <= next_hard;
        end
    end
endmodule

// ==== include/mcr_map.svh ====
`ifndef MCR_MAP_SVH
`define MCR_MAP_SVH
`define MCR_CODE_NONE 8'h00
`define MCR_CODE_UNKNOWN_MM 8'h01
`define MCR_CODE_BAD_INT_ID 8'h02
`define MCR_CODE_IMPOSSIBLE 8'h03
`define MCR_CODE_STRING 8'h04
`define MCR_CODE_ASYNC 8'h05
`define MCR_CODE_SYNC 8'h06
`define MCR_STR_ILLEGAL 2'h3
`define MCR_CODE_MSB 23
`define MCR_CODE_LSB 16
`define MCR_RESTART_BIT 7
`define MCR_STALL_TIME_NS 1000000
`define MCR_CLK_PERIOD_NS 50
`define MCR_STALL_CYCLES (`MCR_STALL_TIME_NS / `MCR_CLK_PERIOD_NS)
`endif

// ==== include/mcr_pkg.sv ====
package mcr_pkg;
    typedef enum logic [1:0]
    {
        MCR_IDLE = 2'b00,
        MCR_TRAP = 2'b01,
        MCR_WAIT = 2'b10
    } mcr_state_t;

    typedef struct packed
    {
        logic unknown_mm_status;
        logic bad_interrupt_id;
        logic impossible_dispatch;
        logic string_active;
        logic [1:0] string_state;
    } mcr_ucode_err_t;

    typedef struct packed
    {
        logic fetch_err;
        logic read_err;
        logic consume;
        logic discard;
        logic pte_write_err;
    } mcr_sync_err_t;

    typedef struct packed
    {
        logic lost_err;
        logic lost_data;
        logic write_lost_set;
        logic write_lost_clr;
    } mcr_lost_t;
endpackage

// ==== sim/mcr_top_properties.sv ====
`timescale 1ns/1ps
module mcr_top_properties (
    input wire logic clk,
    input wire logic rst,
    input mcr_pkg::mcr_ucode_err_t ucode_err,
    input mcr_pkg::mcr_sync_err_t sync_err,
    input mcr_pkg::mcr_lost_t lost,
    input wire logic tb_hit,
    input wire logic tb_parity_err,
    input wire logic tb_lock_clr,
    input wire logic mchk_trap,
    input wire logic [31:0] frame_word1,
    input wire logic [7:0] cause_code,
    input wire logic tb_lock,
    input wire logic stall_timeout_flag,
    input wire logic write_lost,
    input wire logic soft_err_int,
    input wire logic hard_err_int
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_tb_err;
        tb_hit && tb_parity_err;
    endsequence
    sequence s_async_trap;
        mchk_trap && cause_code == 8'h05;
    endsequence
    AST_FRAME: assert property (
        frame_word1 == {8'h00, cause_code, 16'h0000})
        else $error("cause code misplaced in frame word");
    AST_LOCK_SET: assert property (s_tb_err |=> tb_lock)
        else $error("parity error did not lock");
    AST_LOCK_HOLD: assert property (
        tb_lock && !tb_lock_clr |=> tb_lock)
        else $error("lock dropped without clear");
    AST_HARD_WL: assert property (write_lost |-> hard_err_int)
        else $error("write lost without hard interrupt");
    AST_HARD_LOST: assert property (
        lost.lost_err && lost.lost_data |=> hard_err_int)
        else $error("lost data without hard interrupt");
    AST_STRING: assert property (
        mchk_trap && cause_code == 8'h04
            |-> $past(ucode_err.string_active) &&
            $past(ucode_err.string_state) == 2'h3)
        else $error("string check without illegal state");
    AST_SOFT: assert property (
        soft_err_int == $past((sync_err.fetch_err || sync_err.read_err)
            && sync_err.discard && !sync_err.consume))
        else $error("soft interrupt mismatch");
    AST_TIMEOUT: assert property (
        $rose(stall_timeout_flag) |-> ##[0:3] s_async_trap)
        else $error("timeout without async check");
endmodule
bind mcr_top mcr_top_properties chk_u (.*);

// ==== sim/mcr_top_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) \
    begin \
        checks++; \
        if ((s) !== (e)) \
        begin \
            $display("BAD %s exp %0h got %0h", n, e, s); \
            mismatches++; \
        end \
    end
module mcr_top_tb_top;
    typedef struct packed
    {
        logic [5:0] u;
        logic [4:0] s;
        logic sc;
        logic [7:0] c;
        logic r;
    } mcr_row_t;
    logic clk = 0, rst = 1, tb_hit = 0, tb_parity_err = 0, tb_lock_clr = 0;
    logic s3_stall = 0, s3_advance = 0, stall_timeout_clr = 0;
    logic state_changed = 0, mchk_ack = 0;
    mcr_pkg::mcr_ucode_err_t ucode_err = '0;
    mcr_pkg::mcr_sync_err_t sync_err = '0;
    mcr_pkg::mcr_lost_t lost = '0;
    logic mchk_trap, restart_indicator, tb_lock, stall_timeout_flag;
    logic write_lost, soft_err_int, hard_err_int;
    logic [31:0] frame_word1;
    logic [7:0] cause_code;
    int mismatches = 0, checks = 0, traps = 0, t0;
    mcr_row_t rows [8] = '{
        {6'h20, 5'h00, 1'b0, 8'h01, 1'b1}, {6'h10, 5'h00, 1'b1, 8'h02, 1'b0},
        {6'h08, 5'h00, 1'b0, 8'h03, 1'b1}, {6'h07, 5'h00, 1'b0, 8'h04, 1'b1},
        {6'h00, 5'h14, 1'b1, 8'h06, 1'b1}, {6'h00, 5'h0c, 1'b1, 8'h06, 1'b0},
        {6'h30, 5'h14, 1'b1, 8'h01, 1'b0}, {6'h00, 5'h01, 1'b0, 8'h06, 1'b1}};
    mcr_top #(.STALL_CYCLES(8)) dut_u (.*);
    always #25 clk = ~clk;
    always @(posedge clk) if (mchk_trap === 1'b1) traps++;
    task give_verdict;
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task wait_trap;
        int i;
        i = 0;
        while (mchk_trap !== 1'b1)
        begin
            @(posedge clk);
            #1;
            i++;
            if (i > 30)
            begin
                mismatches++;
                give_verdict;
            end
        end
    endtask
    // error levels are dropped with the ack so they cannot retrigger
    task ack;
        @(posedge clk);
        ucode_err <= '0;
        sync_err <= '0;
        tb_parity_err <= 0;
        s3_stall <= 0;
        mchk_ack <= 1;
        @(posedge clk);
        mchk_ack <= 0;
        repeat (3) @(posedge clk);
    endtask
    task drive_pulse(input int k, input logic v);
        case (k)
            0: tb_lock_clr <= v;
            1: s3_advance <= v;
            default: stall_timeout_clr <= v;
        endcase
    endtask
    task pulse(input int k);
        @(posedge clk);
        drive_pulse(k, 1'b1);
        @(posedge clk);
        drive_pulse(k, 1'b0);
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        #1;
        `CHK("reset", 12'h000, {tb_lock, write_lost, hard_err_int, mchk_trap, cause_code})
        foreach (rows[k])
        begin
            @(posedge clk);
            ucode_err <= rows[k].u;
            sync_err <= rows[k].s;
            state_changed <= rows[k].sc;
            wait_trap;
            `CHK("cause", rows[k].c, cause_code)
            `CHK("frame", {8'h00, rows[k].c, 16'h0000}, frame_word1)
            `CHK("restart", rows[k].r, restart_indicator)
            ack;
        end
        @(posedge clk);
        tb_hit <= 1;
        tb_parity_err <= 1;
        wait_trap;
        `CHK("tb cause", 8'h05, cause_code)
        ack;
        `CHK("tb lock", 1'b1, tb_lock)
        pulse(0);
        `CHK("tb lock clr", 1'b0, tb_lock)
        // advance after 6 stalled cycles must restart the count
        @(posedge clk);
        s3_stall <= 1;
        repeat (5) @(posedge clk);
        pulse(1);
        repeat (3) @(posedge clk);
        #1;
        `CHK("stall early", 1'b0, stall_timeout_flag)
        wait_trap;
        `CHK("stall cause", 8'h05, cause_code)
        ack;
        `CHK("stall flag", 1'b1, stall_timeout_flag)
        pulse(2);
        `CHK("stall clr", 1'b0, stall_timeout_flag)
        // set and clear in one cycle: the set must win
        @(posedge clk);
        lost <= 4'h3;
        @(posedge clk);
        lost <= 4'h0;
        #1;
        `CHK("wl hard", 2'h3, {write_lost, hard_err_int})
        @(posedge clk);
        #1;
        `CHK("wl hold", 2'h3, {write_lost, hard_err_int})
        // clearing write_lost drops the hard interrupt; lost_err raises it only with lost_data
        @(posedge clk);
        lost <= 4'h9;
        @(posedge clk);
        lost <= 4'h0;
        #1;
        `CHK("no data", 2'h0, {write_lost, hard_err_int})
        @(posedge clk);
        lost <= 4'hc;
        @(posedge clk);
        lost <= 4'h0;
        #1;
        `CHK("data lost", 1'b1, hard_err_int)
        t0 = traps;
        @(posedge clk);
        sync_err <= 5'h0a;
        lost <= 4'h2;
        repeat (3) @(posedge clk);
        #1;
        `CHK("soft", 1'b1, soft_err_int)
        `CHK("no trap", t0, traps)
        // mid-run reset with flags and a cause still standing
        @(posedge clk);
        sync_err <= '0;
        lost <= '0;
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        #1;
        `CHK("rst flags", 4'h0, {write_lost, hard_err_int, soft_err_int, mchk_trap})
        `CHK("rst frame", 32'h00000000, frame_word1)
        give_verdict;
    end
endmodule
